// >>> verilog/apc_defines.svh
// How it works
// - mid register bits drive channels 8 to 15
// - high register bits drive channels 16 to 23
// - zero keeps port control, one disables it
// - converter off in reset or channel all ones
// - idle lowest power between conversions
// - raw result eleven or nine bits
// - ten-bit mode rounds, splits high and low
// - eight-bit mode rounds into low only
// - done flag set, interrupt if enabled
// - compare enable gates result storage
// - four selectable converter source clocks
// - selected source divided makes conversion clock
// - reset selects undivided bus clock
// - halved bus clock with divide by eight gives sixteen
// - internal async clock runs in low power
// - divider ratios one, two, four, eight
// - disabled pin: output, input, pullup off
// - port read returns zero on disabled pins
// - low register bits drive channels 0 to 7
// - source codes bus, half, alternate, async
// - divide codes one, two, four, eight
// - mode 00 eight-bit, 10 ten-bit
`ifndef APC_DEFINES_SVH
`define APC_DEFINES_SVH
`define APC_ADDR_W 4
`define APC_A_PDL 4'h0
`define APC_A_PDM 4'h1
`define APC_A_PDH 4'h2
`define APC_A_SC1 4'h3
`define APC_A_SC2 4'h4
`define APC_A_CFG 4'h5
`define APC_A_RH 4'h6
`define APC_A_RL 4'h7
`define APC_A_CVH 4'h8
`define APC_A_CVL 4'h9
`define APC_CH_OFF 5'h1f
`define APC_CH_RST 5'h1f
`define APC_CFG_RST 8'h00
`define APC_MODE_8 2'h0
`define APC_MODE_10 2'h2
`define APC_SRC_BUS 2'h0
`define APC_SRC_HALF 2'h1
`define APC_SRC_ALT 2'h2
`define APC_SRC_ASYNC 2'h3
`define APC_SC1_DONE 7
`define APC_SC1_IEN 6
`define APC_SC2_CFE 5
`define APC_SC2_CFG 4
`define APC_SC2_BUSY 7
`define APC_CFG_DIV 6:5
`define APC_CFG_MODE 3:2
`define APC_CFG_SRC 1:0
`endif

// >>> verilog/apc_pkg.sv
package apc_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} apc_bus_t;
	typedef struct packed {
		logic [23:0] out_en_n_force;
		logic [23:0] in_buf_off;
		logic [23:0] pullup_off;
	} apc_pin_t;
	typedef enum logic [1:0] {
		APC_IDLE = 2'b00,
		APC_RUN = 2'b01,
		APC_STORE = 2'b11
	} apc_state_t;
endpackage

// >>> verilog/apc_ctrl.sv
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "apc_defines.svh"
module apc_ctrl (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register port
	input wire apc_pkg::apc_bus_t bus,
	output logic [7:0] rdata,
	// port pins
	input wire logic [23:0] port_in,
	output logic [23:0] port_read,
	output apc_pkg::apc_pin_t pin,
	// converter core
	input wire logic alternate_clock_input,
	input wire logic async_tick,
	input wire logic core_done,
	input wire logic [10:0] core_raw,
	output logic core_enable,
	output logic core_start,
	output logic core_async_on,
	output logic conversion_clock,
	output logic irq
);
	import apc_pkg::*;

	logic [7:0] analog_pin_disable_low;
	logic [7:0] analog_pin_disable_mid;
	logic [7:0] analog_pin_disable_high;
	logic [4:0] input_channel_select;
	logic done_irq_enable;
	logic conversion_done_flag;
	logic compare_enable;
	logic compare_greater;
	logic [7:0] cfg;
	logic [1:0] result_high;
	logic [7:0] result_low;
	logic [1:0] cmp_high;
	logic [7:0] cmp_low;
	logic half_tgl;
	logic alt_q;
	logic src_tick;
	logic [2:0] div_cnt;
	logic [2:0] div_last;
	logic [9:0] next_result;
	logic [10:0] raw_q;
	logic cmp_ok;
	logic store;
	logic [23:0] dis;
	apc_state_t state;

	// round the raw value by adding its dropped half bit
	function automatic logic [9:0] round_raw(input logic [10:0] raw, input logic ten);
		logic [11:0] s;
		s = 12'h000;
		if (ten)
			s = {1'b0, raw} + 12'h001;
		else
			s = {3'b000, raw[8:0]} + 12'h001;
		if (ten)
			round_raw = s[11] ? 10'h3ff : s[10:1];
		else
			round_raw = s[9] ? 10'h0ff : {2'b00, s[8:1]};
	endfunction

	wire ten_bit = (cfg[`APC_CFG_MODE] == `APC_MODE_10);
	wire wr_sc1 = bus.wr && bus.addr == `APC_A_SC1;
	wire cfg_write = bus.wr && (bus.addr == `APC_A_SC2 || bus.addr == `APC_A_CFG ||
		bus.addr == `APC_A_CVH || bus.addr == `APC_A_CVL);

	// pin disable registers, cleared at reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			analog_pin_disable_low <= 8'h00;
			analog_pin_disable_mid <= 8'h00;
			analog_pin_disable_high <= 8'h00;
		end else if (bus.wr) begin
			if (bus.addr == `APC_A_PDL)
				analog_pin_disable_low <= bus.wdata;
			if (bus.addr == `APC_A_PDM)
				analog_pin_disable_mid <= bus.wdata;
			if (bus.addr == `APC_A_PDH)
				analog_pin_disable_high <= bus.wdata;
		end
	end

	// channel n follows bit n of the concatenated registers
	assign dis = {analog_pin_disable_high, analog_pin_disable_mid, analog_pin_disable_low};
	assign pin.out_en_n_force = dis;
	assign pin.in_buf_off = dis;
	assign pin.pullup_off = dis;
	assign port_read = port_in & ~dis;

	// control and configuration registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			input_channel_select <= `APC_CH_RST;
			done_irq_enable <= 1'b0;
			compare_enable <= 1'b0;
			compare_greater <= 1'b0;
			cfg <= `APC_CFG_RST;
			cmp_high <= 2'h0;
			cmp_low <= 8'h00;
		end else if (bus.wr) begin
			unique case (bus.addr)
				`APC_A_SC1: begin
					done_irq_enable <= bus.wdata[`APC_SC1_IEN];
					input_channel_select <= bus.wdata[4:0];
				end
				`APC_A_SC2: begin
					compare_enable <= bus.wdata[`APC_SC2_CFE];
					compare_greater <= bus.wdata[`APC_SC2_CFG];
				end
				`APC_A_CFG: cfg <= bus.wdata;
				`APC_A_CVH: cmp_high <= bus.wdata[1:0];
				`APC_A_CVL: cmp_low <= bus.wdata;
				default: ;
			endcase
		end
	end

	// source clock ticks; alternate clock edge found from the live input and one registered sample
	always_ff @(posedge mclk) begin
		if (rst) begin
			half_tgl <= 1'b0;
			alt_q <= 1'b0;
		end else begin
			half_tgl <= ~half_tgl;
			alt_q <= alternate_clock_input;
		end
	end

	always_comb begin
		unique case (cfg[`APC_CFG_SRC])
			`APC_SRC_BUS: src_tick = 1'b1;
			`APC_SRC_HALF: src_tick = half_tgl;
			`APC_SRC_ALT: src_tick = alternate_clock_input & ~alt_q;
			`APC_SRC_ASYNC: src_tick = async_tick;
		endcase
	end

	// ratio minus one; an enable pulse, not a derived clock, avoids skew
	always_comb begin
		unique case (cfg[`APC_CFG_DIV])
			2'h0: div_last = 3'h0;
			2'h1: div_last = 3'h1;
			2'h2: div_last = 3'h3;
			2'h3: div_last = 3'h7;
		endcase
	end

	// free-running divider producing the conversion clock enable
	always_ff @(posedge mclk) begin
		if (rst) begin
			div_cnt <= 3'h0;
			conversion_clock <= 1'b0;
		end else begin
			conversion_clock <= 1'b0;
			if (src_tick) begin
				if (div_cnt >= div_last) begin
					div_cnt <= 3'h0;
					conversion_clock <= 1'b1;
				end else
					div_cnt <= div_cnt + 3'h1;
			end
		end
	end

	// compare with the rounded value; limitation: eight-bit compares low byte only
	always_comb begin
		next_result = round_raw(raw_q, ten_bit);
		if (!compare_enable)
			cmp_ok = 1'b1;
		else if (ten_bit)
			cmp_ok = compare_greater ? (next_result >= {cmp_high, cmp_low}) : (next_result < {cmp_high, cmp_low});
		else
			cmp_ok = compare_greater ? (next_result[7:0] >= cmp_low) : (next_result[7:0] < cmp_low);
	end

	// conversion sequence; config writes abort a running conversion
	always_ff @(posedge mclk) begin
		if (rst)
			state <= APC_IDLE;
		else if (wr_sc1)
			state <= (bus.wdata[4:0] == `APC_CH_OFF) ? APC_IDLE : APC_RUN;
		else if (cfg_write)
			state <= APC_IDLE;
		else begin
			unique case (state)
				APC_IDLE: state <= APC_IDLE;
				APC_RUN: if (core_done) state <= APC_STORE;
				APC_STORE: state <= APC_IDLE;
				default: state <= APC_IDLE;
			endcase
		end
	end

	assign store = state == APC_STORE && cmp_ok;
	assign core_enable = !rst && input_channel_select != `APC_CH_OFF && state != APC_IDLE;
	assign core_start = wr_sc1 && bus.wdata[4:0] != `APC_CH_OFF;
	assign core_async_on = core_enable && cfg[`APC_CFG_SRC] == `APC_SRC_ASYNC;

	// raw value captured with the done pulse; the core may drop it one cycle later
	always_ff @(posedge mclk) begin
		if (rst)
			raw_q <= 11'h000;
		else if (state == APC_RUN && core_done)
			raw_q <= core_raw;
	end

	// result placement from the captured raw value
	always_ff @(posedge mclk) begin
		if (rst) begin
			result_high <= 2'h0;
			result_low <= 8'h00;
		end else if (store) begin
			result_low <= next_result[7:0];
			if (ten_bit)
				result_high <= next_result[9:8];
		end
	end

	// done flag: storing wins over the clearing write to the control register
	always_ff @(posedge mclk) begin
		if (rst)
			conversion_done_flag <= 1'b0;
		else if (store)
			conversion_done_flag <= 1'b1;
		else if (wr_sc1 || (bus.rd && bus.addr == `APC_A_RL))
			conversion_done_flag <= 1'b0;
	end

	assign irq = conversion_done_flag && done_irq_enable;

	// read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge mclk) begin
		if (rst)
			rdata <= 8'h00;
		else if (bus.rd) begin
			unique case (bus.addr)
				`APC_A_PDL: rdata <= analog_pin_disable_low;
				`APC_A_PDM: rdata <= analog_pin_disable_mid;
				`APC_A_PDH: rdata <= analog_pin_disable_high;
				`APC_A_SC1: rdata <= {conversion_done_flag, done_irq_enable, 1'b0, input_channel_select};
				`APC_A_SC2: rdata <= {state != APC_IDLE, 1'b0, compare_enable, compare_greater, 4'h0};
				`APC_A_CFG: rdata <= cfg;
				`APC_A_RH: rdata <= {6'h00, result_high};
				`APC_A_RL: rdata <= result_low;
				`APC_A_CVH: rdata <= {6'h00, cmp_high};
				`APC_A_CVL: rdata <= cmp_low;
				default: rdata <= 8'h00;
			endcase
		end else
			rdata <= 8'h00;
	end
endmodule // apc_ctrl

// >>> test/apc_checker.sv
`timescale 1ns/10ps
module apc_checker (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// watched ports
	input wire apc_pkg::apc_bus_t bus,
	input wire logic [23:0] port_in,
	input wire logic [23:0] port_read,
	input wire apc_pkg::apc_pin_t pin,
	input wire logic core_done,
	input wire logic core_enable,
	input wire logic core_start,
	input wire logic irq
);
	import apc_pkg::*;
	default clocking @(posedge mclk); endclocking
	// the three pin masks always agree, reads hide disabled pins
	pin_read_a: assert property (port_read == (port_in & ~pin.in_buf_off))
		else $error("port read not masked");
	pin_force_a: assert property (pin.out_en_n_force == pin.in_buf_off)
		else $error("output force differs");
	pin_pull_a: assert property (pin.pullup_off == pin.in_buf_off)
		else $error("pullup differs");
	reset_pins_a: assert property (rst |=> pin.in_buf_off == 24'h00_0000)
		else $error("pins not released by reset");
	reset_off_a: assert property (rst |=> !core_enable && !irq)
		else $error("converter on in reset");
	// start and stop follow the channel select write
	start_go_a: assert property (disable iff (rst) bus.wr && bus.addr == 4'h3 && bus.wdata[4:0] != 5'h1f |-> ##[0:1] core_start)
		else $error("no start");
	chan_off_a: assert property (disable iff (rst) bus.wr && bus.addr == 4'h3 && bus.wdata[4:0] == 5'h1f |=> !core_enable)
		else $error("not disabled");
	irq_cause_a: assert property (disable iff (rst) $rose(irq) |-> $past(core_done, 2) || $past(bus.wr))
		else $error("irq without cause");
	idle_hold_a: assert property (disable iff (rst) core_done ##1 !bus.wr |-> !core_start)
		else $error("start without request");
endmodule // apc_checker
bind apc_ctrl apc_checker i_chk (.mclk(mclk), .rst(rst), .bus(bus), .port_in(port_in), .port_read(port_read),
	.pin(pin), .core_done(core_done), .core_enable(core_enable), .core_start(core_start), .irq(irq));

// >>> test/apc_core_model.sv
`timescale 1ns/10ps
module apc_core_model (
	// control from the block
	input wire logic mclk,
	input wire logic core_enable,
	input wire logic core_start,
	input wire logic core_async_on,
	// conversion chosen by the bench
	input wire logic [10:0] raw_in,
	input wire logic [3:0] lat,
	// answers
	output logic core_done = 0,
	output logic [10:0] core_raw = 0,
	output logic async_tick = 0
);
	logic [3:0] cnt = 0;
	logic [1:0] ac = 0;
	// a start loads the conversion time, loss of power aborts it
	always @(posedge mclk) begin
		core_done <= cnt == 4'h1 && core_enable;
		core_raw <= (cnt == 4'h1) ? raw_in : ~core_raw; // 11-bit raw, junk between results
		cnt <= core_start ? lat : (cnt != 4'h0 && core_enable) ? cnt - 4'h1 : 4'h0;
	end
	// own generator, ticks every fourth cycle while on
	always @(posedge mclk) begin
		async_tick <= core_async_on && ac == 2'h0;
		ac <= ac + 2'h1;
	end
endmodule // apc_core_model

// >>> test/testbench.sv
`timescale 1ns/10ps
module testbench;
	import apc_pkg::*;
	logic mclk = 0;
	logic rst = 1;
	apc_bus_t bus = '0;
	logic [23:0] port_in = 0;
	logic alt_clk = 0;
	logic [10:0] raw_in = 0;
	logic [3:0] lat = 4'h2;
	logic [7:0] rdata, d;
	logic [23:0] port_read, m;
	apc_pin_t pin;
	logic async_tick, core_done, core_enable, core_start, core_async_on, conversion_clock, irq, md;
	logic [10:0] core_raw;
	logic [9:0] e;
	int seed = 32'hc53f;
	int checks = 0;
	int num_errors = 0;
	int n;
	always #12.5 mclk = ~mclk;
	// alternate source toggles so it rises every second cycle
	always @(posedge mclk) alt_clk <= ~alt_clk;
	apc_ctrl i_dut (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .port_in(port_in), .port_read(port_read),
		.pin(pin), .alternate_clock_input(alt_clk), .async_tick(async_tick), .core_done(core_done),
		.core_raw(core_raw), .core_enable(core_enable), .core_start(core_start),
		.core_async_on(core_async_on), .conversion_clock(conversion_clock), .irq(irq));
	apc_core_model i_core (.mclk(mclk), .core_enable(core_enable), .core_start(core_start),
		.core_async_on(core_async_on), .raw_in(raw_in), .lat(lat), .core_done(core_done),
		.core_raw(core_raw), .async_tick(async_tick));
	// bus cycles leave a gap so no strobe is driven twice in one step
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		bus <= '{a, v, 1'b1, 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1;
		v = rdata;
		@(posedge mclk);
	endtask
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
		checks++;
		if (y !== x) begin
			num_errors++;
			$display("Error %s expected %h seen %h", s, x, y);
		end
	endtask
	// rounding to the mode's width, saturated at full scale
	function automatic logic [9:0] rnd(input logic [10:0] r, input logic ten);
		logic [11:0] s;
		s = ten ? ({1'b0, r} + 12'h001) >> 1 : ({3'h0, r[8:0]} + 12'h001) >> 1;
		if (!ten && s > 12'h0ff)
			s = 12'h0ff;
		if (s > 12'h3ff)
			s = 12'h3ff;
		return s[9:0];
	endfunction
	task conclude;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// a hang counts as a mismatch
	initial begin
		#400000;
		num_errors++;
		conclude;
	end
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		chk("core_enable", 0, core_enable);
		for (int a = 0; a < 6; a++) begin
			rd(a[3:0], d);
			chk("reset_value", (a == 3) ? 8'h1f : 8'h00, d);
		end
		rd(4'hf, d);
		chk("unmapped", 0, d);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			m = (i == 0) ? 24'hff_ffff : 24'($random(seed));
			port_in <= 24'($random(seed));
			wr(4'h0, m[7:0]);
			wr(4'h1, m[15:8]);
			wr(4'h2, m[23:16]);
			chk("in_buf_off", m, pin.in_buf_off);
			chk("out_force", m, pin.out_en_n_force);
			chk("pullup_off", m, pin.pullup_off);
			chk("port_read", port_in & ~m, port_read);
			for (int a = 0; a < 3; a++) begin
				rd(a[3:0], d);
				chk("pin_disable", m[8*a+:8], d);
			end
		end
		$display("test pins done");
		for (int i = 0; i < 6; i++) begin
			md = i[0];
			raw_in <= (i < 2) ? 11'h7ff : 11'($random(seed));
			lat <= {1'b0, 3'($random(seed))} + 4'h2;
			wr(4'h5, md ? 8'h08 : 8'h00);
			wr(4'h3, 8'h40);
			for (int k = 0; k < 40 && irq !== 1'b1; k++)
				@(posedge mclk);
			chk("irq", 1, irq);
			e = rnd(raw_in, md);
			if (md) begin
				rd(4'h6, d);
				chk("result_high", e[9:8], d);
			end
			rd(4'h7, d);
			chk("result_low", e[7:0], d);
			chk("irq_clear", 0, irq);
		end
		// compare gate: a failing result is dropped, a passing one is stored
		wr(4'h5, 8'h00);
		wr(4'h4, 8'h30);
		wr(4'h9, 8'h80);
		raw_in <= 11'h0fe;
		wr(4'h3, 8'h40);
		repeat (30) @(posedge mclk);
		chk("cmp_block", 0, irq);
		raw_in <= 11'h100;
		wr(4'h3, 8'h40);
		for (int k = 0; k < 40 && irq !== 1'b1; k++)
			@(posedge mclk);
		chk("cmp_pass", 1, irq);
		rd(4'h7, d);
		chk("cmp_result", 8'h80, d);
		wr(4'h4, 8'h00);
		wr(4'h3, 8'h1f);
		chk("core_enable", 0, core_enable);
		$display("test conversion done");
		for (int s = 0; s < 3; s++) begin
			for (int v = 0; v < 4; v++) begin
				wr(4'h5, {1'b0, v[1:0], 3'h0, s[1:0]});
				repeat (20) @(posedge mclk);
				n = 0;
				repeat (64) begin
					@(posedge mclk);
					n += conversion_clock;
				end
				chk("ratio", 64 >> (v + (s != 0)), n);
			end
		end
		$display("test divider done");
		conclude;
	end
endmodule // testbench
